//--- led_post_defines.svh
// constants for the indicator lamp and configuration switch block
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
`ifndef LED_POST_DEFINES_SVH
`define LED_POST_DEFINES_SVH

// register byte offsets
`define REG_STATUS       12'h000
`define REG_LAMP_CTRL    12'h004
`define REG_GP_OUT       12'h008
`define REG_PORT80       12'h00C
`define REG_POST_CODE    12'h010
`define REG_FAULTS       12'h014

// status fields
`define ST_SW_LSB        0
`define ST_BOOT_DONE     4
`define ST_PHASE_LSB     5

// lamp control fields
`define CTRL_MODE_LSB    0
`define CTRL_BOOT_DONE   4

// fault bits in the fault register, one per red lamp
`define FLT_FW_BOOT      0
`define FLT_HW_RESET     1
`define FLT_CPU_CAT      2
`define FLT_POWER        3

// reset values
`define LAMP_CTRL_RESET  4'h0
`define GP_OUT_RESET     4'h0

// multiplex hold time per display state
`define PHASE_HOLD_MS    500
`define CLK_MHZ          100
`define PHASE_HOLD_CYC   (`PHASE_HOLD_MS * 1000 * `CLK_MHZ)

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

//--- led_post_pkg.sv
// types for the indicator lamp and configuration switch block
// assumes led_post_defines.svh supplies the numeric constants
package led_post_pkg;

    // multiplex display states: dark marker, upper nibble, lower nibble
    typedef enum logic [1:0] {
        PH_DARK,
        PH_HIGH,
        PH_LOW
    } mux_phase_t;

endpackage

//--- nibble_mux.sv
// nibble multiplexer: cycles dark, upper, lower and holds each state
// assumes a single aclk with synchronous active-low reset
`timescale 1ns/1ns
`include "led_post_defines.svh"

module nibble_mux
    import led_post_pkg::*;
#(
    parameter int HOLD_CYCLES = `PHASE_HOLD_CYC
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic [7:0]       code,
    output led_post_pkg::mux_phase_t phase,
    output logic      [3:0]       lamps
);
    import led_post_pkg::*;

    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    mux_phase_t  next_phase;
    logic [3:0]  next_lamps;

    // advance the phase after each hold period
    always_comb
    begin
        next_hold_cnt = hold_cnt;
        next_phase    = phase;
        if (!run)
        begin
            next_hold_cnt = 32'h0000_0000;
            next_phase    = PH_DARK;
        end
        else if (hold_cnt >= 32'(HOLD_CYCLES - 1))
        begin
            next_hold_cnt = 32'h0000_0000;
            case (phase)
                PH_DARK: next_phase = PH_HIGH;
                PH_HIGH: next_phase = PH_LOW;
                default: next_phase = PH_DARK;
            endcase
        end
        else
        begin
            next_hold_cnt = hold_cnt + 32'h0000_0001;
        end
    end

    // lamp n carries bit n+4 in the upper phase, bit n in the lower
    always_comb
    begin
        case (next_phase)
            PH_HIGH: next_lamps = code[7:4];
            PH_LOW:  next_lamps = code[3:0];
            default: next_lamps = 4'h0;
        endcase
        if (!run)
        begin
            next_lamps = 4'h0;
        end
    end

    // state registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_cnt <= 32'h0000_0000;
            phase    <= PH_DARK;
            lamps    <= 4'h0;
        end
        else
        begin
            hold_cnt <= next_hold_cnt;
            phase    <= next_phase;
            lamps    <= next_lamps;
        end
    end

endmodule

//--- post_code_led_indicator.sv
// indicator lamp and configuration switch block with AXI4-Lite registers
// assumes switch and fault inputs synchronous to aclk; switch level 0 = on
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "led_post_defines.svh"

module post_code_led_indicator
    import led_post_pkg::*;
#(
    parameter int HOLD_CYCLES = `PHASE_HOLD_CYC
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // board side
    input  wire logic [3:0]  config_switch_bank,
    input  wire logic        fault_power,
    input  wire logic        fault_cpu_catastrophic,
    input  wire logic        fault_hw_reset,
    input  wire logic        fault_fw_boot,
    input  wire logic        reset_event,
    output logic [3:0]       lamp_red,
    output logic [3:0]       lamp_green,
    output logic             recovery_flash_select,
    output logic             chipset_power_good,
    output logic             settings_clear
);
    import led_post_pkg::*;

    logic       progress_display_switch;
    logic       flash_select_switch;
    logic       reset_cycle_switch;
    logic       settings_clear_switch;
    logic [3:0] sw_q;
    logic [3:0] faults;
    logic [3:0] lamp_mode;
    logic [3:0] gp_out;
    logic [7:0] port80;
    logic [7:0] post_code;
    logic       boot_done;
    logic [7:0] mux_code;
    logic       mux_run;
    mux_phase_t phase;
    logic [3:0] mux_lamps;

    // switch levels: 0 means the switch is on
    assign progress_display_switch = sw_q[0];
    assign flash_select_switch     = sw_q[1];
    assign reset_cycle_switch      = sw_q[2];
    assign settings_clear_switch   = sw_q[3];

    // axi write channel state
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic [3:0]  next_lamp_mode;
    logic [3:0]  next_gp_out;
    logic [7:0]  next_port80;
    logic [7:0]  next_post_code;
    logic        next_boot_done;
    logic        do_write;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    // capture address and data in either order, commit when both held
    always_comb
    begin
        next_aw_held   = aw_held;
        next_w_held    = w_held;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_lamp_mode = lamp_mode;
        next_gp_out    = gp_out;
        next_port80    = port80;
        next_post_code = post_code;
        next_boot_done = boot_done;
        do_write       = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (next_aw_held && next_w_held)
        begin
            do_write     = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_OKAY;
            if (next_aw_addr == `REG_LAMP_CTRL)
            begin
                if (next_w_strb[0])
                begin
                    next_lamp_mode = next_w_data[`CTRL_MODE_LSB +: 4];
                    next_boot_done = next_w_data[`CTRL_BOOT_DONE];
                end
            end
            else if (next_aw_addr == `REG_GP_OUT)
            begin
                if (next_w_strb[0])
                    next_gp_out = next_w_data[3:0];
            end
            else if (next_aw_addr == `REG_PORT80)
            begin
                if (next_w_strb[0])
                    next_port80 = next_w_data[7:0];
            end
            else if (next_aw_addr == `REG_POST_CODE)
            begin
                if (next_w_strb[0])
                    next_post_code = next_w_data[7:0];
            end
            else if (next_aw_addr == `REG_STATUS || next_aw_addr == `REG_FAULTS)
            begin
                next_bresp = `RESP_OKAY; // read-only, write ignored
            end
            else
            begin
                next_bresp = `RESP_SLVERR;
            end
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
    end

    // read channel
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    assign s_axi_arready = !s_axi_rvalid;

    // address decode for reads
    always_comb
    begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr == `REG_STATUS)
            begin
                next_rdata[`ST_SW_LSB +: 4]    = sw_q;
                next_rdata[`ST_BOOT_DONE]      = boot_done;
                next_rdata[`ST_PHASE_LSB +: 2] = phase;
            end
            else if (s_axi_araddr == `REG_LAMP_CTRL)
            begin
                next_rdata[`CTRL_MODE_LSB +: 4] = lamp_mode;
                next_rdata[`CTRL_BOOT_DONE]     = boot_done;
            end
            else if (s_axi_araddr == `REG_GP_OUT)
                next_rdata[3:0] = gp_out;
            else if (s_axi_araddr == `REG_PORT80)
                next_rdata[7:0] = port80;
            else if (s_axi_araddr == `REG_POST_CODE)
                next_rdata[7:0] = post_code;
            else if (s_axi_araddr == `REG_FAULTS)
                next_rdata[3:0] = faults;
            else
                next_rresp = `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    // progress code multiplexer, also used for port-80 after boot
    always_comb
    begin
        if (!boot_done)
        begin
            mux_code = post_code;
            mux_run  = progress_display_switch;
        end
        else
        begin
            mux_code = port80;
            mux_run  = |lamp_mode;
        end
    end

    nibble_mux #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_mux (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (mux_run),
        .code    (mux_code),
        .phase   (phase),
        .lamps   (mux_lamps)
    );

    // lamp drive and board control outputs
    logic [3:0] next_lamp_red;
    logic [3:0] next_lamp_green;
    logic       next_power_good;

    always_comb
    begin
        next_lamp_red   = 4'h0;
        next_lamp_green = 4'h0;
        if (!boot_done)
        begin
            next_lamp_red   = faults;
            next_lamp_green = mux_lamps;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                next_lamp_green[i] = lamp_mode[i] ? mux_lamps[i] : gp_out[i];
            end
        end
        // power cycle drops power-good for a reset event when switch 2 on
        next_power_good = !(reset_event && !reset_cycle_switch);
    end

    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_q                  <= 4'hF;
            faults                <= 4'h0;
            aw_held               <= 1'b0;
            w_held                <= 1'b0;
            aw_addr               <= 12'h000;
            w_data                <= 32'h0000_0000;
            w_strb                <= 4'h0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `RESP_OKAY;
            s_axi_rvalid          <= 1'b0;
            s_axi_rdata           <= 32'h0000_0000;
            s_axi_rresp           <= `RESP_OKAY;
            lamp_mode             <= `LAMP_CTRL_RESET;
            gp_out                <= `GP_OUT_RESET;
            port80                <= 8'h00;
            post_code             <= 8'h00;
            boot_done             <= 1'b0;
            lamp_red              <= 4'h0;
            lamp_green            <= 4'h0;
            recovery_flash_select <= 1'b0;
            chipset_power_good    <= 1'b1;
            settings_clear        <= 1'b0;
        end
        else
        begin
            sw_q                  <= config_switch_bank;
            faults                <= {fault_power, fault_cpu_catastrophic,
                                      fault_hw_reset, fault_fw_boot};
            aw_held               <= next_aw_held;
            w_held                <= next_w_held;
            aw_addr               <= next_aw_addr;
            w_data                <= next_w_data;
            w_strb                <= next_w_strb;
            s_axi_bvalid          <= next_bvalid;
            s_axi_bresp           <= next_bresp;
            s_axi_rvalid          <= next_rvalid;
            s_axi_rdata           <= next_rdata;
            s_axi_rresp           <= next_rresp;
            lamp_mode             <= next_lamp_mode;
            gp_out                <= next_gp_out;
            port80                <= next_port80;
            post_code             <= next_post_code;
            boot_done             <= next_boot_done;
            lamp_red              <= next_lamp_red;
            lamp_green            <= next_lamp_green;
            recovery_flash_select <= !flash_select_switch;
            chipset_power_good    <= next_power_good;
            settings_clear        <= !settings_clear_switch;
        end
    end

endmodule

//--- led_post_checker.sv
// port checker for the indicator lamp block
// assumes it is bound onto post_code_led_indicator, one clock domain
`timescale 1ns/1ns

module led_post_checker #(
    parameter int HOLD_CYCLES = 6
)
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0]  config_switch_bank,
    input wire logic        fault_power,
    input wire logic        fault_cpu_catastrophic,
    input wire logic        fault_hw_reset,
    input wire logic        fault_fw_boot,
    input wire logic        reset_event,
    input wire logic [3:0]  lamp_red,
    input wire logic        recovery_flash_select,
    input wire logic        chipset_power_good,
    input wire logic        settings_clear
);
    logic [3:0] fault_vec;

    // fault inputs in red lamp order
    assign fault_vec = {fault_power, fault_cpu_catastrophic, fault_hw_reset, fault_fw_boot};

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // switch driven board controls and red lamps, two register stages from the switches and faults, one from reset_event
    flash_rec_a: assert property (
        (!config_switch_bank[1])[*3] |-> recovery_flash_select)
        else $error("recovery flash not selected");
    flash_std_a: assert property (
        (config_switch_bank[1])[*3] |-> !recovery_flash_select)
        else $error("standard flash not selected");
    power_cycle_a: assert property (
        (reset_event && !config_switch_bank[2])[*3] |-> !chipset_power_good)
        else $error("power good kept during reset");
    power_keep_a: assert property ((!reset_event)[*3] |-> chipset_power_good)
        else $error("power good dropped without reset");
    clear_on_a: assert property ((!config_switch_bank[3])[*3] |-> settings_clear)
        else $error("settings clear missing");
    clear_off_a: assert property ((config_switch_bank[3])[*3] |-> !settings_clear)
        else $error("settings clear without switch");
    red_map_a: assert property (lamp_red != 4'h0 |-> lamp_red == $past(fault_vec, 2))
        else $error("red lamp without matching fault");

    // bus handshakes
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write response late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data kept after handshake");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule

bind post_code_led_indicator led_post_checker #(.HOLD_CYCLES(HOLD_CYCLES)) i_led_post_checker (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .config_switch_bank, .fault_power,
    .fault_cpu_catastrophic, .fault_hw_reset, .fault_fw_boot, .reset_event,
    .lamp_red, .recovery_flash_select, .chipset_power_good, .settings_clear);

//--- lamp_switch_model.sv
// far side model: switch bank and green lamp reader
// assumes lamps sampled on aclk and the same hold count as the block
`timescale 1ns/1ns

module lamp_switch_model #(
    parameter int HOLD_CYCLES = 6
)
(
    input  wire logic [3:0] switch_on,
    input  wire logic       aclk,
    input  wire logic [3:0] lamp_green,
    output logic      [3:0] config_switch_bank,
    output logic      [7:0] code_seen,
    output int              code_cnt
);
    logic [3:0] last_val;
    logic [3:0] prev_val;
    logic [3:0] old_val;
    int         run_len;
    int         prev_len;

    // a closed switch pulls its line low
    assign config_switch_bank = ~switch_on;

    initial
    begin
        code_cnt = 0;
        code_seen = 8'h00;
        last_val = 4'h0;
        prev_val = 4'hF;
        old_val = 4'hF;
        run_len = 0;
        prev_len = 0;
    end

    // a dark run, then upper and lower runs of the hold length, form one code
    always @(posedge aclk)
    begin
        if (lamp_green === last_val)
            run_len <= run_len + 1;
        else
        begin
            if (old_val == 4'h0 && prev_len == HOLD_CYCLES
                && run_len == HOLD_CYCLES)
            begin
                code_seen <= {prev_val, last_val};
                code_cnt <= code_cnt + 1;
            end
            old_val <= prev_val;
            prev_val <= last_val;
            prev_len <= run_len;
            last_val <= lamp_green;
            run_len <= 1;
        end
    end
endmodule

//--- test_post_code_led_indicator.sv
// self-checking bench for the indicator lamp block
// assumes checker and far side model are compiled before it
`timescale 1ns/1ns
`include "led_post_defines.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module test_post_code_led_indicator;
    localparam int HOLD = 6;
    logic        aclk, aresetn, reset_event;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb, fault_bits, switch_on, lamp_red, lamp_green, config_switch_bank;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        recovery_flash_select, chipset_power_good, settings_clear;
    logic [7:0]  code_seen;
    int          code_cnt, err_total, checks_done;
    int          cyc = 0;

    post_code_led_indicator #(.HOLD_CYCLES(HOLD)) i_post_code_led_indicator (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .config_switch_bank,
        .fault_power(fault_bits[3]), .fault_cpu_catastrophic(fault_bits[2]),
        .fault_hw_reset(fault_bits[1]), .fault_fw_boot(fault_bits[0]), .reset_event,
        .lamp_red, .lamp_green, .recovery_flash_select, .chipset_power_good,
        .settings_clear);

    lamp_switch_model #(.HOLD_CYCLES(HOLD)) i_lamp_switch_model (
        .switch_on, .aclk, .lamp_green, .config_switch_bank, .code_seen, .code_cnt);

    // clock and hang guard
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // bus write: address and data together, bready up until the response
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        `CHK("bresp", `RESP_OKAY, s_axi_bresp)
        // handshake edge, then one idle edge so the next call starts cleanly
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    // bus read into rd_data and rd_resp, rready up until the data come
    task automatic axi_rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic next_code();
        int c0;
        c0 = code_cnt;
        while (code_cnt < c0 + 2)
            @(posedge aclk);
    endtask

    task automatic t_reset();
        axi_rd(`REG_LAMP_CTRL);
        `CHK("lamp_ctrl", 32'h0000_0000, rd_data)
        axi_rd(`REG_GP_OUT);
        `CHK("gp_out", 32'h0000_0000, rd_data)
        axi_rd(12'h0FC);
        `CHK("unmapped", `RESP_SLVERR, rd_resp)
        $display("test reset done");
    endtask

    task automatic t_red();
        for (int i = 0; i < 4; i++)
        begin
            fault_bits <= 4'h1 << i;
            tick(3);
            `CHK("red", 4'h1 << i, lamp_red)
        end
        fault_bits <= 4'h0;
        $display("test red done");
    endtask

    task automatic t_post();
        int c0;
        axi_wr(`REG_POST_CODE, 32'h0000_0041);
        next_code();
        `CHK("post_code", 8'h41, code_seen)
        switch_on <= 4'h1;
        tick(3);
        c0 = code_cnt;
        tick(40);
        `CHK("no_display", 4'h0, lamp_green)
        `CHK("no_codes", c0, code_cnt)
        switch_on <= 4'h0;
        $display("test post done");
    endtask

    task automatic t_switch();
        for (int i = 0; i < 16; i += 5)
        begin
            switch_on <= 4'(i);
            tick(3);
            `CHK("flash", i[1], recovery_flash_select)
            `CHK("clear", i[3], settings_clear)
            axi_rd(`REG_STATUS);
            `CHK("sw_status", ~4'(i), rd_data[3:0])
            reset_event <= 1'b1;
            tick(3);
            `CHK("pwr_good", ~i[2], chipset_power_good)
            reset_event <= 1'b0;
        end
        switch_on <= 4'h0;
        $display("test switch done");
    endtask

    task automatic t_after();
        fault_bits <= 4'h8;
        axi_wr(`REG_LAMP_CTRL, 32'h0000_0010);
        axi_wr(`REG_GP_OUT, 32'h0000_000A);
        tick(3);
        `CHK("gp_lamps", 4'hA, lamp_green)
        `CHK("red_after", 4'h0, lamp_red)
        axi_wr(`REG_PORT80, 32'h0000_00A5);
        axi_wr(`REG_LAMP_CTRL, 32'h0000_001F);
        next_code();
        `CHK("port80", 8'hA5, code_seen)
        fault_bits <= 4'h0;
        $display("test after boot done");
    endtask

    // main sequence
    initial
    begin
        err_total = 0;
        checks_done = 0;
        aresetn = 1'b0;
        reset_event = 1'b0;
        fault_bits = 4'h0;
        switch_on = 4'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        tick(2);
        aresetn <= 1'b1;
        t_reset();
        t_red();
        t_post();
        t_switch();
        t_after();
        complete_run();
    end
endmodule
